// file: verilog/speed_reference_profile_regs.v
// Speed-reference profile configuration register bank
//
// Notes on behaviour
// RQ1 - Bits 30-29 word one select mapping mode
// RQ2 - Word one bits 28-21: first turn-on duty
// RQ3 - Word one bits 20-13: first turn-off duty
// RQ4 - Word one bits 12-5: first clamp duty
// RQ5 - Duty A joins word one 4-0, word two 30-28
// RQ6 - Duties B, C, D in word two
// RQ7 - Duty E joins word two 3-0, word three 30-27
// RQ8 - Second turn-on, turn-off duty in word three
// RQ9 - Word three bits 10-3: second clamp duty
// RQ10 - Word three bits 2-1 pick hysteresis step
// RQ11 - Word four bits 30-23: first turn-off reference
// RQ12 - Word four bits 22-15: first clamp reference
// RQ13 - Word four bits 14-7: breakpoint reference A
// RQ14 - Word four bits 6-0: reference B upper
// RQ15 - Word five bit 30: reference B lowest
// RQ16 - Every word clears to zero on reset
// RQ17 - Reads return last written; splits join late
`default_nettype none
`include "speed_profile_defines.vh"

module speed_reference_profile_regs (
  input  wire                 clk_sys,
  input  wire                 arst_n,
  input  wire                 wr_en,
  input  wire                 rd_en,
  input  wire [`ADDR_W-1:0]   addr,
  input  wire [`WORD_W-1:0]   wr_data,
  output reg  [`WORD_W-1:0]   rd_data,
  output reg                  rd_valid,
  output reg                  rd_unmapped,
  output reg  [1:0]           profile_mode,
  output reg                  mode_equation,
  output reg                  mode_linear,
  output reg                  mode_staircase,
  output reg                  mode_fwd_rev,
  output reg  [7:0]           turn_on_duty_first,
  output reg  [7:0]           turn_off_duty_first,
  output reg  [7:0]           clamp_duty_first,
  output wire [7:0]           duty_a,
  output reg  [7:0]           duty_b,
  output reg  [7:0]           duty_c,
  output reg  [7:0]           duty_d,
  output wire [7:0]           duty_e,
  output reg  [7:0]           turn_on_duty_second,
  output reg  [7:0]           turn_off_duty_second,
  output reg  [7:0]           clamp_duty_second,
  output reg  [1:0]           duty_hysteresis_sel,
  output reg  [2:0]           duty_hysteresis_half_pct,
  output reg  [7:0]           turn_off_reference_first,
  output reg  [7:0]           clamp_reference_first,
  output reg  [7:0]           reference_a,
  output wire [7:0]           reference_b,
  output wire                 duty_a_pending,
  output wire                 duty_e_pending,
  output wire                 reference_b_pending
);

  // ==========================================================
  // Address decode
  // Odd and unlisted offsets decode to no word
  function [2:0] word_index;
    input [`ADDR_W-1:0] a;
    begin
      case (a)
        `OFS_SELECT_DUTY: word_index = `IDX_SELECT_DUTY;
        `OFS_BREAKPOINTS: word_index = `IDX_BREAKPOINTS;
        `OFS_SECOND_DUTY: word_index = `IDX_SECOND_DUTY;
        `OFS_REF_LEVELS:  word_index = `IDX_REF_LEVELS;
        `OFS_REF_UPPER:   word_index = `IDX_REF_UPPER;
        default:          word_index = `IDX_NONE;
      endcase
    end
  endfunction

  wire [2:0] wr_idx = word_index(addr);
  wire [2:0] rd_idx = word_index(addr);

  // ==========================================================
  // Write strobes
  // One strobe per word; unmapped offsets raise none
  wire [`NUM_WORDS-1:0] wr_hit;

  assign wr_hit[`IDX_SELECT_DUTY] = wr_en && (wr_idx == `IDX_SELECT_DUTY);
  assign wr_hit[`IDX_BREAKPOINTS] = wr_en && (wr_idx == `IDX_BREAKPOINTS);
  assign wr_hit[`IDX_SECOND_DUTY] = wr_en && (wr_idx == `IDX_SECOND_DUTY);
  assign wr_hit[`IDX_REF_LEVELS]  = wr_en && (wr_idx == `IDX_REF_LEVELS);
  assign wr_hit[`IDX_REF_UPPER]   = wr_en && (wr_idx == `IDX_REF_UPPER);

  // ==========================================================
  // Storage words
  wire [`NUM_WORDS*`WORD_W-1:0] words;
  wire [`NUM_WORDS-1:0]         written;

  genvar i;
  generate
    for (i = 0; i < `NUM_WORDS; i = i + 1) begin : g_word
      // RQ16 cleared on reset
      profile_word u_word (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .wr_en   (wr_hit[i]),
        .wr_data (wr_data),
        .value   (words[i*`WORD_W +: `WORD_W]),
        .written (written[i])
      );
    end
  endgenerate

  wire [`WORD_W-1:0] w_select =
    words[`IDX_SELECT_DUTY*`WORD_W +: `WORD_W];
  wire [`WORD_W-1:0] w_breaks =
    words[`IDX_BREAKPOINTS*`WORD_W +: `WORD_W];
  wire [`WORD_W-1:0] w_second =
    words[`IDX_SECOND_DUTY*`WORD_W +: `WORD_W];
  wire [`WORD_W-1:0] w_levels =
    words[`IDX_REF_LEVELS*`WORD_W +: `WORD_W];
  wire [`WORD_W-1:0] w_upper =
    words[`IDX_REF_UPPER*`WORD_W +: `WORD_W];

  // ==========================================================
  // Read port
  reg [`WORD_W-1:0] next_rd_data;
  reg               next_unmapped;

  always @* begin
    next_rd_data  = `WORD_RESET;
    next_unmapped = 1'b0;
    if (rd_idx == `IDX_NONE) begin
      next_unmapped = rd_en;
    end else begin
      // RQ17 readback as written
      next_rd_data = words[rd_idx*`WORD_W +: `WORD_W];
    end
  end

  // Strobes last one cycle per read
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_valid    <= 1'b0;
      rd_unmapped <= 1'b0;
    end else begin
      rd_valid    <= rd_en;
      rd_unmapped <= next_unmapped;
    end
  end

  // Read of a word written in the same cycle returns the old value;
  // data then holds until the next read
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= `WORD_RESET;
    end else if (rd_en) begin
      rd_data <= next_rd_data;
    end
  end

  // ==========================================================
  // Split fields
  // RQ5 duty A halves joined
  split_join #(
    .HI_W (`DUTY_A_UP_HI-`DUTY_A_UP_LO+1),
    .LO_W (`DUTY_A_DN_HI-`DUTY_A_DN_LO+1)
  ) u_duty_a (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .hi_part    (w_select[`DUTY_A_UP_HI:`DUTY_A_UP_LO]),
    .lo_part    (w_breaks[`DUTY_A_DN_HI:`DUTY_A_DN_LO]),
    .hi_written (written[`IDX_SELECT_DUTY]),
    .lo_written (written[`IDX_BREAKPOINTS]),
    .value      (duty_a),
    .pending    (duty_a_pending)
  );

  // RQ7 duty E halves joined
  split_join #(
    .HI_W (`DUTY_E_UP_HI-`DUTY_E_UP_LO+1),
    .LO_W (`DUTY_E_DN_HI-`DUTY_E_DN_LO+1)
  ) u_duty_e (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .hi_part    (w_breaks[`DUTY_E_UP_HI:`DUTY_E_UP_LO]),
    .lo_part    (w_second[`DUTY_E_DN_HI:`DUTY_E_DN_LO]),
    .hi_written (written[`IDX_BREAKPOINTS]),
    .lo_written (written[`IDX_SECOND_DUTY]),
    .value      (duty_e),
    .pending    (duty_e_pending)
  );

  // RQ14 upper seven bits
  // RQ15 lowest bit from fifth word
  split_join #(
    .HI_W (`REF_B_UP_HI-`REF_B_UP_LO+1),
    .LO_W (1)
  ) u_ref_b (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .hi_part    (w_levels[`REF_B_UP_HI:`REF_B_UP_LO]),
    .lo_part    (w_upper[`REF_B_DN]),
    .hi_written (written[`IDX_REF_LEVELS]),
    .lo_written (written[`IDX_REF_UPPER]),
    .value      (reference_b),
    .pending    (reference_b_pending)
  );

  // ==========================================================
  // Field slices
  // Word one
  wire [1:0] mode_field    = w_select[`MODE_HI:`MODE_LO];
  wire [7:0] on1_field     = w_select[`ON1_HI:`ON1_LO];
  wire [7:0] off1_field    = w_select[`OFF1_HI:`OFF1_LO];
  wire [7:0] clamp1_field  = w_select[`CLAMP1_HI:`CLAMP1_LO];

  // Word two
  wire [7:0] b_field       = w_breaks[`DUTY_B_HI:`DUTY_B_LO];
  wire [7:0] c_field       = w_breaks[`DUTY_C_HI:`DUTY_C_LO];
  wire [7:0] d_field       = w_breaks[`DUTY_D_HI:`DUTY_D_LO];

  // Word three
  wire [7:0] on2_field     = w_second[`ON2_HI:`ON2_LO];
  wire [7:0] off2_field    = w_second[`OFF2_HI:`OFF2_LO];
  wire [7:0] clamp2_field  = w_second[`CLAMP2_HI:`CLAMP2_LO];
  wire [1:0] hys_field     = w_second[`HYS_HI:`HYS_LO];

  // Word four
  wire [7:0] roff1_field   = w_levels[`ROFF1_HI:`ROFF1_LO];
  wire [7:0] rclamp1_field = w_levels[`RCLAMP1_HI:`RCLAMP1_LO];
  wire [7:0] ref_a_field   = w_levels[`REF_A_HI:`REF_A_LO];

  // ==========================================================
  // Mode and hysteresis decode
  reg [2:0] next_hys_half;
  reg [3:0] next_mode_hot;

  always @* begin
    // RQ10 hysteresis in half-percent steps
    case (hys_field)
      `HYS_CODE_0: next_hys_half = `HYS_HALF_0;
      `HYS_CODE_1: next_hys_half = `HYS_HALF_1;
      `HYS_CODE_2: next_hys_half = `HYS_HALF_2;
      `HYS_CODE_3: next_hys_half = `HYS_HALF_3;
      default:     next_hys_half = `HYS_HALF_0;
    endcase
  end

  always @* begin
    // RQ1 mapping mode one-hot
    case (mode_field)
      `MODE_EQUATION:  next_mode_hot = 4'h1;
      `MODE_LINEAR:    next_mode_hot = 4'h2;
      `MODE_STAIRCASE: next_mode_hot = 4'h4;
      `MODE_FWD_REV:   next_mode_hot = 4'h8;
      default:         next_mode_hot = 4'h1;
    endcase
  end

  // ==========================================================
  // Mode outputs
  // Registered so every field lags its word by one edge,
  // matching the split joins
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      profile_mode   <= `MODE_EQUATION;
      mode_equation  <= 1'b1;
      mode_linear    <= 1'b0;
      mode_staircase <= 1'b0;
      mode_fwd_rev   <= 1'b0;
    end else begin
      // RQ1 mode select
      profile_mode   <= mode_field;
      mode_equation  <= next_mode_hot[0];
      mode_linear    <= next_mode_hot[1];
      mode_staircase <= next_mode_hot[2];
      mode_fwd_rev   <= next_mode_hot[3];
    end
  end

  // ==========================================================
  // First range duties
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      turn_on_duty_first  <= `FIELD_RESET;
      turn_off_duty_first <= `FIELD_RESET;
      clamp_duty_first    <= `FIELD_RESET;
    end else begin
      // RQ2 first turn-on
      turn_on_duty_first  <= on1_field;
      // RQ3 first turn-off
      turn_off_duty_first <= off1_field;
      // RQ4 first clamp
      clamp_duty_first    <= clamp1_field;
    end
  end

  // ==========================================================
  // Breakpoint duties
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      duty_b <= `FIELD_RESET;
      duty_c <= `FIELD_RESET;
      duty_d <= `FIELD_RESET;
    end else begin
      // RQ6 breakpoint duties
      duty_b <= b_field;
      duty_c <= c_field;
      duty_d <= d_field;
    end
  end

  // ==========================================================
  // Second range duties and hysteresis
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      turn_on_duty_second      <= `FIELD_RESET;
      turn_off_duty_second     <= `FIELD_RESET;
      clamp_duty_second        <= `FIELD_RESET;
      duty_hysteresis_sel      <= `HYS_CODE_0;
      duty_hysteresis_half_pct <= `HYS_HALF_0;
    end else begin
      // RQ8 second turn-on, turn-off
      turn_on_duty_second      <= on2_field;
      turn_off_duty_second     <= off2_field;
      // RQ9 second clamp
      clamp_duty_second        <= clamp2_field;
      // RQ10 hysteresis select
      duty_hysteresis_sel      <= hys_field;
      duty_hysteresis_half_pct <= next_hys_half;
    end
  end

  // ==========================================================
  // Reference levels
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      turn_off_reference_first <= `FIELD_RESET;
      clamp_reference_first    <= `FIELD_RESET;
      reference_a              <= `FIELD_RESET;
    end else begin
      // RQ11 first turn-off reference
      turn_off_reference_first <= roff1_field;
      // RQ12 first clamp reference
      clamp_reference_first    <= rclamp1_field;
      // RQ13 breakpoint reference A
      reference_a              <= ref_a_field;
    end
  end

endmodule
`default_nettype wire

// file: verilog/speed_profile_defines.vh
// Constants for the speed-reference profile register bank
`ifndef SPEED_PROFILE_DEFINES_VH
`define SPEED_PROFILE_DEFINES_VH

// ==========================================================
// Word geometry and reset
`define WORD_W          32
`define ADDR_W          8
`define NUM_WORDS       5
`define WORD_RESET      32'h0000_0000
`define FIELD_RESET     8'h00

// ==========================================================
// Byte offsets as printed
`define OFS_SELECT_DUTY 8'h94
`define OFS_BREAKPOINTS 8'h96
`define OFS_SECOND_DUTY 8'h98
`define OFS_REF_LEVELS  8'h9a
`define OFS_REF_UPPER   8'h9c

// ==========================================================
// Word indices
`define IDX_SELECT_DUTY 3'h0
`define IDX_BREAKPOINTS 3'h1
`define IDX_SECOND_DUTY 3'h2
`define IDX_REF_LEVELS  3'h3
`define IDX_REF_UPPER   3'h4
`define IDX_NONE        3'h7

// ==========================================================
// First word fields
`define MODE_HI         30
`define MODE_LO         29
`define ON1_HI          28
`define ON1_LO          21
`define OFF1_HI         20
`define OFF1_LO         13
`define CLAMP1_HI       12
`define CLAMP1_LO       5
`define DUTY_A_UP_HI    4
`define DUTY_A_UP_LO    0

// ==========================================================
// Second word fields
`define DUTY_A_DN_HI    30
`define DUTY_A_DN_LO    28
`define DUTY_B_HI       27
`define DUTY_B_LO       20
`define DUTY_C_HI       19
`define DUTY_C_LO       12
`define DUTY_D_HI       11
`define DUTY_D_LO       4
`define DUTY_E_UP_HI    3
`define DUTY_E_UP_LO    0

// ==========================================================
// Third word fields
`define DUTY_E_DN_HI    30
`define DUTY_E_DN_LO    27
`define ON2_HI          26
`define ON2_LO          19
`define OFF2_HI         18
`define OFF2_LO         11
`define CLAMP2_HI       10
`define CLAMP2_LO       3
`define HYS_HI          2
`define HYS_LO          1

// ==========================================================
// Fourth and fifth word fields
`define ROFF1_HI        30
`define ROFF1_LO        23
`define RCLAMP1_HI      22
`define RCLAMP1_LO      15
`define REF_A_HI        14
`define REF_A_LO        7
`define REF_B_UP_HI     6
`define REF_B_UP_LO     0
`define REF_B_DN        30

// ==========================================================
// Mapping modes and hysteresis codes
`define MODE_EQUATION   2'h0
`define MODE_LINEAR     2'h1
`define MODE_STAIRCASE  2'h2
`define MODE_FWD_REV    2'h3
`define HYS_CODE_0      2'h0
`define HYS_CODE_1      2'h1
`define HYS_CODE_2      2'h2
`define HYS_CODE_3      2'h3
`define HYS_HALF_0      3'h0
`define HYS_HALF_1      3'h1
`define HYS_HALF_2      3'h2
`define HYS_HALF_3      3'h4

`endif

// file: verilog/profile_word.v
// One read-write 32-bit profile configuration word
`default_nettype none
`include "speed_profile_defines.vh"

module profile_word (
  input  wire                 clk_sys,
  input  wire                 arst_n,
  input  wire                 wr_en,
  input  wire [`WORD_W-1:0]   wr_data,
  output reg  [`WORD_W-1:0]   value,
  output reg                  written
);

  // ==========================================================
  // Storage
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      value   <= `WORD_RESET;
      written <= 1'b0;
    end else begin
      // Whole word kept, reserved bit too
      if (wr_en) begin
        value <= wr_data;
      end
      written <= wr_en;
    end
  end

endmodule
`default_nettype wire

// file: verilog/split_join.v
// Joins a field split over two words once both halves are written
`default_nettype none
`include "speed_profile_defines.vh"

module split_join #(
  parameter HI_W = 5,
  parameter LO_W = 3
) (
  input  wire                 clk_sys,
  input  wire                 arst_n,
  input  wire [HI_W-1:0]      hi_part,
  input  wire [LO_W-1:0]      lo_part,
  input  wire                 hi_written,
  input  wire                 lo_written,
  output reg  [HI_W+LO_W-1:0] value,
  output reg                  pending
);

  // ==========================================================
  // Pending halves
  reg  hi_pend;
  reg  lo_pend;
  wire hi_seen = hi_pend | hi_written;
  wire lo_seen = lo_pend | lo_written;
  wire both    = hi_seen & lo_seen;

  // Half-updated values never reach the profile logic
  // RQ17 join once both written
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      value   <= {(HI_W+LO_W){1'b0}};
      hi_pend <= 1'b0;
      lo_pend <= 1'b0;
      pending <= 1'b0;
    end else if (both) begin
      value   <= {hi_part, lo_part};
      hi_pend <= 1'b0;
      lo_pend <= 1'b0;
      pending <= 1'b0;
    end else begin
      hi_pend <= hi_seen;
      lo_pend <= lo_seen;
      pending <= hi_seen | lo_seen;
    end
  end

endmodule
`default_nettype wire

// file: verification/profile_regs_asserts.sv
// Assertion checker for the profile register bank
`default_nettype none

module profile_regs_asserts (
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wr_data,
  input wire logic [31:0] rd_data,
  input wire logic        rd_valid,
  input wire logic        rd_unmapped,
  input wire logic [1:0]  profile_mode,
  input wire logic        mode_linear,
  input wire logic [7:0]  turn_on_duty_first,
  input wire logic [7:0]  duty_a,
  input wire logic [7:0]  duty_b,
  input wire logic [1:0]  duty_hysteresis_sel,
  input wire logic [2:0]  duty_hysteresis_half_pct,
  input wire logic        duty_a_pending
);
  timeunit 1ns;
  timeprecision 1ps;

  wire mapped = !addr[0] && addr >= 8'h94 && addr <= 8'h9c;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  // ====
  // Read port
  a_read_answer: assert property (rd_en |=> rd_valid)
    else $error("read not answered");
  a_unmapped_zero: assert property (
    rd_en && !mapped |=> rd_unmapped && rd_data == 32'h0)
    else $error("unmapped read not flagged");
  a_write_readback: assert property (
    wr_en && mapped ##1 !wr_en ##1 rd_en && !wr_en
    && addr == $past(addr, 2) |=> rd_data == $past(wr_data, 3))
    else $error("readback differs from write");

  // ====
  // Field outputs, two edges after the write
  a_mode_field: assert property (
    wr_en && addr == 8'h94 |-> ##2
    profile_mode == $past(wr_data[30:29], 2))
    else $error("mode field wrong");
  a_mode_onehot: assert property (
    mode_linear == (profile_mode == 2'h1))
    else $error("linear decode wrong");
  a_on_duty: assert property (
    wr_en && addr == 8'h94 |-> ##2
    turn_on_duty_first == $past(wr_data[28:21], 2))
    else $error("turn on duty wrong");
  a_duty_b: assert property (
    wr_en && addr == 8'h96 |-> ##2 duty_b == $past(wr_data[27:20], 2))
    else $error("duty b wrong");
  a_hys_decode: assert property (
    duty_hysteresis_half_pct == (duty_hysteresis_sel == 2'h3 ?
    3'h4 : {1'b0, duty_hysteresis_sel}))
    else $error("hysteresis decode wrong");
  // Half-written split must not leak into the joined value
  a_join_hold: assert property (!$stable(duty_a) |-> !duty_a_pending)
    else $error("duty a moved while pending");
  a_reset_clear: assert property (
    $rose(arst_n) |-> rd_data == 32'h0 && profile_mode == 2'h0
    && !duty_a_pending)
    else $error("state not clear after reset");

  c_join_done: cover property (duty_a_pending ##1 !duty_a_pending);
  c_wr_rd_same: cover property (wr_en && rd_en);
  c_unmapped: cover property (rd_unmapped);
endmodule

bind speed_reference_profile_regs profile_regs_asserts chk (
  .clk_sys, .arst_n, .wr_en, .rd_en, .addr, .wr_data, .rd_data,
  .rd_valid, .rd_unmapped, .profile_mode, .mode_linear,
  .turn_on_duty_first, .duty_a, .duty_b, .duty_hysteresis_sel,
  .duty_hysteresis_half_pct, .duty_a_pending
);
`default_nettype wire

// file: verification/speed_reference_profile_regs_test.sv
// Self-checking bench for the profile register bank
`default_nettype none

module speed_reference_profile_regs_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ====
  // Design ports
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic [31:0] rd_data;
  logic        rd_valid, rd_unmapped, mode_equation, mode_linear;
  logic        mode_staircase, mode_fwd_rev, duty_a_pending;
  logic        duty_e_pending, reference_b_pending;
  logic [1:0]  profile_mode, duty_hysteresis_sel;
  logic [2:0]  duty_hysteresis_half_pct;
  logic [7:0]  turn_on_duty_first, turn_off_duty_first, clamp_duty_first;
  logic [7:0]  duty_a, duty_b, duty_c, duty_d, duty_e, reference_a;
  logic [7:0]  turn_on_duty_second, turn_off_duty_second;
  logic [7:0]  clamp_duty_second, turn_off_reference_first;
  logic [7:0]  clamp_reference_first, reference_b;

  // ====
  // Bench state: shadow words and split-field model
  int          n_fail = 0;
  int          total_checks = 0;
  logic [31:0] w [0:4];
  logic [7:0]  jv [0:2];
  logic [2:0]  fh, fl;
  int          hi_i [0:2] = '{0, 1, 3};
  int          lo_i [0:2] = '{1, 2, 4};
  logic [31:0] got;
  logic        unm;
  // Address, write data, read result, unmapped flag
  logic [72:0] rows [0:11] = '{
    {8'h94, 32'ha5c3_1e97, 32'ha5c3_1e97, 1'b0},
    {8'h96, 32'h7bad_f00d, 32'h7bad_f00d, 1'b0},
    {8'h98, 32'h8123_4562, 32'h8123_4562, 1'b0},
    {8'h9a, 32'hffff_ffff, 32'hffff_ffff, 1'b0},
    {8'h9c, 32'h4000_0001, 32'h4000_0001, 1'b0},
    {8'h94, 32'h4321_abcd, 32'h4321_abcd, 1'b0},
    {8'h98, 32'h5a5a_a5a4, 32'h5a5a_a5a4, 1'b0},
    {8'h94, 32'h6f0f_0f0f, 32'h6f0f_0f0f, 1'b0},
    {8'h98, 32'h0000_0007, 32'h0000_0007, 1'b0},
    {8'h94, 32'h8000_0000, 32'h8000_0000, 1'b0},
    {8'h9e, 32'h1234_5678, 32'h0000_0000, 1'b1},
    {8'h95, 32'hffff_ffff, 32'h0000_0000, 1'b1}};

  always #5 clk_sys = ~clk_sys;

  speed_reference_profile_regs dut (
    .clk_sys, .arst_n, .wr_en, .rd_en, .addr, .wr_data, .rd_data,
    .rd_valid, .rd_unmapped, .profile_mode, .mode_equation,
    .mode_linear, .mode_staircase, .mode_fwd_rev,
    .turn_on_duty_first, .turn_off_duty_first, .clamp_duty_first,
    .duty_a, .duty_b, .duty_c, .duty_d, .duty_e,
    .turn_on_duty_second, .turn_off_duty_second, .clamp_duty_second,
    .duty_hysteresis_sel, .duty_hysteresis_half_pct,
    .turn_off_reference_first, .clamp_reference_first, .reference_a,
    .reference_b, .duty_a_pending, .duty_e_pending, .reference_b_pending);

  // ====
  // Compare and closing tasks
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_flag(input logic g, input logic e);
    chk_word({31'h0, g}, {31'h0, e});
  endtask

  task automatic close_out;
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ====
  // Shadow model
  function automatic int idx(input logic [7:0] a);
    if (a[0] || a < 8'h94 || a > 8'h9c)
      return -1;
    return int'((a - 8'h94) >> 1);
  endfunction

  function automatic logic [7:0] joined(input int j);
    case (j)
      0: return {w[0][4:0], w[1][30:28]};
      1: return {w[1][3:0], w[2][30:27]};
      default: return {w[3][6:0], w[4][30]};
    endcase
  endfunction

  // Unmapped writes leave the shadow alone
  task automatic note(input logic [7:0] a, input logic [31:0] d);
    int k;
    k = idx(a);
    if (k < 0)
      return;
    w[k] = d;
    for (int j = 0; j < 3; j++) begin
      fh[j] = fh[j] | (k == hi_i[j]);
      fl[j] = fl[j] | (k == lo_i[j]);
      if (fh[j] && fl[j]) begin
        jv[j] = joined(j);
        fh[j] = 1'b0;
        fl[j] = 1'b0;
      end
    end
  endtask

  task automatic check_fields;
    chk_word({1'b0, profile_mode, turn_on_duty_first, turn_off_duty_first,
      clamp_duty_first, 5'h0}, {1'b0, w[0][30:5], 5'h0});
    chk_word({28'h0, mode_fwd_rev, mode_staircase, mode_linear,
      mode_equation}, 32'h1 << w[0][30:29]);
    chk_word({4'h0, duty_b, duty_c, duty_d, 4'h0},
      {4'h0, w[1][27:4], 4'h0});
    chk_word({5'h0, turn_on_duty_second, turn_off_duty_second,
      clamp_duty_second, duty_hysteresis_sel, 1'b0},
      {5'h0, w[2][26:1], 1'b0});
    chk_word({29'h0, duty_hysteresis_half_pct}, w[2][2:1] == 2'h3 ?
      32'h4 : {30'h0, w[2][2:1]});
    chk_word({1'b0, turn_off_reference_first, clamp_reference_first,
      reference_a, 7'h0}, {1'b0, w[3][30:7], 7'h0});
    chk_word({8'h0, duty_a, duty_e, reference_b},
      {8'h0, jv[0], jv[1], jv[2]});
    chk_word({29'h0, duty_a_pending, duty_e_pending, reference_b_pending},
      {29'h0, fh[0] | fl[0], fh[1] | fl[1], fh[2] | fl[2]});
  endtask

  // ====
  // Register port tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    note(a, d);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic u);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    chk_flag(rd_valid, 1'b1);
    d = rd_data;
    u = rd_unmapped;
  endtask

  task automatic do_reset;
    @(posedge clk_sys);
    arst_n <= 1'b0;
    for (int k = 0; k < 5; k++)
      w[k] = 32'h0;
    jv = '{8'h0, 8'h0, 8'h0};
    fh = 3'h0;
    fl = 3'h0;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
  endtask

  task automatic check_zero;
    for (int k = 0; k < 5; k++) begin
      rd(8'h94 + 8'(2 * k), got, unm);
      chk_word(got, 32'h0);
    end
    check_fields();
  endtask

  // ====
  // Main sequence
  initial begin
    do_reset();
    check_zero();
    for (int r = 0; r < 12; r++) begin
      wr(rows[r][72:65], rows[r][64:33]);
      rd(rows[r][72:65], got, unm);
      chk_word(got, rows[r][32:1]);
      chk_flag(unm, rows[r][0]);
      check_fields();
    end
    // Read and write together: the read sees the older word
    @(posedge clk_sys);
    wr_en <= 1'b1;
    rd_en <= 1'b1;
    addr <= 8'h96;
    wr_data <= 32'h0bad_cafe;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    #1;
    chk_word(rd_data, w[1]);
    note(8'h96, 32'h0bad_cafe);
    rd(8'h96, got, unm);
    chk_word(got, 32'h0bad_cafe);
    check_fields();
    // Writes on consecutive edges complete reference b
    @(posedge clk_sys);
    wr_en <= 1'b1;
    addr <= 8'h9a;
    wr_data <= 32'h7f80_4021;
    note(8'h9a, 32'h7f80_4021);
    @(posedge clk_sys);
    addr <= 8'h9c;
    wr_data <= 32'hc000_0000;
    note(8'h9c, 32'hc000_0000);
    @(posedge clk_sys);
    wr_en <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check_fields();
    // Reset in mid-run with a split half pending
    wr(8'h94, 32'h1fff_ffff);
    @(posedge clk_sys);
    #1;
    check_fields();
    do_reset();
    check_zero();
    close_out();
  end

  initial begin
    repeat (3000) @(posedge clk_sys);
    n_fail++;
    close_out();
  end
endmodule
`default_nettype wire
